// ===== common/bfp_map.vh
// Constants, timing figures and register map of the bridge fault supervisor.
`ifndef BFP_MAP_VH
`define BFP_MAP_VH

// ****************************************************************
// Timing
// ****************************************************************
`define BFP_CLK_MHZ 200
`define BFP_BLANK_NS 1500
`define BFP_BLANK_CYC ((`BFP_BLANK_NS * `BFP_CLK_MHZ + 999) / 1000)

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define BFP_ADR_W 4
`define BFP_REG_STATUS 4'h0
`define BFP_REG_CTRL 4'h4
`define BFP_CTRL_RST 1'b0

// Status fields.
`define BFP_ST_THERMAL 0
`define BFP_ST_OVERCUR 1
`define BFP_ST_UNDERV 2
`define BFP_ST_STANDBY 3
`define BFP_ST_A_DIR 5:4
`define BFP_ST_B_DIR 7:6
`define BFP_ST_FORCE 8

// Channel direction codes.
`define BFP_DIR_STOP 2'h0
`define BFP_DIR_FWD 2'h1
`define BFP_DIR_REV 2'h2

`endif

// ===== hw/bfp_top.v
// Bridge fault supervisor: input decode, fault shutdowns and Wishbone status port.
//
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "bfp_map.vh"

module bfp_top #(
    parameter BLANK_CYC = `BFP_BLANK_CYC,
    parameter CNT_W = 9
) (
    input wire clk,
    input wire sys_rst,
    input wire ch_a_fwd_in,
    input wire ch_a_rev_in,
    input wire ch_b_fwd_in,
    input wire ch_b_rev_in,
    input wire thermal_trip_in,
    input wire thermal_cool_in,
    input wire overcurrent_in,
    input wire supply_low_in,
    output reg ch_a_out_p,
    output reg ch_a_out_n,
    output reg ch_a_out_en,
    output reg ch_b_out_p,
    output reg ch_b_out_n,
    output reg ch_b_out_en,
    output wire thermal_shutdown,
    output wire overcurrent_shutdown,
    output wire undervoltage_lockout,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`BFP_ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // All eight inputs come from pins or analog comparators.
    wire [7:0] raw_in;
    reg [7:0] sync1_r;
    reg [7:0] sync2_r;
    assign raw_in = {supply_low_in, overcurrent_in, thermal_cool_in, thermal_trip_in,
                     ch_b_rev_in, ch_b_fwd_in, ch_a_rev_in, ch_a_fwd_in};

    always @(posedge clk) begin
        if (sys_rst) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    wire a_fwd = sync2_r[0];
    wire a_rev = sync2_r[1];
    wire b_fwd = sync2_r[2];
    wire b_rev = sync2_r[3];
    wire t_trip = sync2_r[4];
    wire t_cool = sync2_r[5];
    wire oc_det = sync2_r[6];
    wire uv_det = sync2_r[7];

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    reg [1:0] a_dir_r;
    reg [1:0] a_dir_nxt;
    reg [1:0] b_dir_r;
    reg [1:0] b_dir_nxt;
    reg standby_r;
    wire standby_now = ~(a_fwd | a_rev | b_fwd | b_rev);

    // Both high keeps the previous direction, so the input that rose first wins.
    always @* begin
        case ({a_rev, a_fwd})
            2'b00: a_dir_nxt = `BFP_DIR_STOP;
            2'b01: a_dir_nxt = `BFP_DIR_FWD;
            2'b10: a_dir_nxt = `BFP_DIR_REV;
            default: a_dir_nxt = a_dir_r;
        endcase
        case ({b_rev, b_fwd})
            2'b00: b_dir_nxt = `BFP_DIR_STOP;
            2'b01: b_dir_nxt = `BFP_DIR_FWD;
            2'b10: b_dir_nxt = `BFP_DIR_REV;
            default: b_dir_nxt = b_dir_r;
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            a_dir_r <= `BFP_DIR_STOP;
            b_dir_r <= `BFP_DIR_STOP;
            standby_r <= 1'b1;
        end else begin
            a_dir_r <= a_dir_nxt;
            b_dir_r <= b_dir_nxt;
            standby_r <= standby_now;
        end
    end

    // ****************************************************************
    // Fault supervision
    // ****************************************************************
    reg therm_r;
    reg oc_r;
    reg uv_r;
    reg [CNT_W-1:0] blank_cnt_r;
    wire blank_done = (blank_cnt_r == BLANK_CYC[CNT_W-1:0] - 1'b1);
    // Leaving standby into any driven mode is the host's release sequence.
    wire oc_release = standby_r & ~standby_now;

    always @(posedge clk) begin
        if (sys_rst) begin
            therm_r <= 1'b0;
            oc_r <= 1'b0;
            uv_r <= 1'b0;
            blank_cnt_r <= {CNT_W{1'b0}};
        end else begin
            // Trip and release use separate comparator levels, giving hysteresis.
            if (t_trip) begin
                therm_r <= 1'b1;
            end else if (t_cool) begin
                therm_r <= 1'b0;
            end
            uv_r <= uv_det;
            // The indication must stay high for the whole interval; any gap restarts it.
            if (!oc_det) begin
                blank_cnt_r <= {CNT_W{1'b0}};
            end else if (!blank_done) begin
                blank_cnt_r <= blank_cnt_r + 1'b1;
            end
            // A trip in the release cycle still wins, so no overcurrent is lost.
            if (oc_det && blank_done) begin
                oc_r <= 1'b1;
            end else if (oc_release) begin
                oc_r <= 1'b0;
            end
        end
    end

    assign thermal_shutdown = therm_r;
    assign overcurrent_shutdown = oc_r;
    assign undervoltage_lockout = uv_r;

    // ****************************************************************
    // Bridge outputs
    // ****************************************************************
    reg force_off_r;
    wire run_ok = ~therm_r & ~oc_r & ~uv_r & ~force_off_r;

    always @(posedge clk) begin
        if (sys_rst) begin
            ch_a_out_p <= 1'b0;
            ch_a_out_n <= 1'b0;
            ch_a_out_en <= 1'b0;
            ch_b_out_p <= 1'b0;
            ch_b_out_n <= 1'b0;
            ch_b_out_en <= 1'b0;
        end else begin
            // Any shutdown or stop releases both half-bridges of a channel.
            ch_a_out_en <= run_ok & (a_dir_nxt != `BFP_DIR_STOP);
            ch_a_out_p <= run_ok & (a_dir_nxt == `BFP_DIR_FWD);
            ch_a_out_n <= run_ok & (a_dir_nxt == `BFP_DIR_REV);
            ch_b_out_en <= run_ok & (b_dir_nxt != `BFP_DIR_STOP);
            ch_b_out_p <= run_ok & (b_dir_nxt == `BFP_DIR_FWD);
            ch_b_out_n <= run_ok & (b_dir_nxt == `BFP_DIR_REV);
        end
    end

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    reg [31:0] rd_nxt;

    always @* begin
        rd_nxt = 32'h00000000;
        case (wb_adr_i)
            `BFP_REG_STATUS: begin
                rd_nxt[`BFP_ST_THERMAL] = therm_r;
                rd_nxt[`BFP_ST_OVERCUR] = oc_r;
                rd_nxt[`BFP_ST_UNDERV] = uv_r;
                rd_nxt[`BFP_ST_STANDBY] = standby_r;
                rd_nxt[`BFP_ST_A_DIR] = a_dir_r;
                rd_nxt[`BFP_ST_B_DIR] = b_dir_r;
                rd_nxt[`BFP_ST_FORCE] = force_off_r;
            end
            `BFP_REG_CTRL: begin
                rd_nxt[0] = force_off_r;
            end
            default: begin
                rd_nxt = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            force_off_r <= `BFP_CTRL_RST;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_nxt : 32'h00000000;
            if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `BFP_REG_CTRL) begin
                force_off_r <= wb_dat_i[0];
            end
        end
    end

endmodule

// ===== testbench/bfp_host.sv
// Host controller model that drives the four bridge control pins.
`timescale 1ns/1ps
module bfp_host (
    input wire clk,
    input wire [3:0] mode,
    input wire clear_req,
    output reg [3:0] pins = 4'h0
);
    reg [2:0] idle_r = 3'h0;
    // Standby is held several cycles so the synchroniser surely sees all four pins low together.
    always @(posedge clk) begin
        if (clear_req)
            idle_r <= 3'h5;
        else if (idle_r != 3'h0)
            idle_r <= idle_r - 3'h1;
        pins <= (clear_req || idle_r != 3'h0) ? 4'h0 : mode;
    end
endmodule

// ===== testbench/bfp_props.sv
// Concurrent checks on the bridge fault supervisor ports.
`timescale 1ns/1ps
module bfp_props #(
    parameter BLANK_CYC = 8
) (
    input wire clk,
    input wire sys_rst,
    input wire ch_a_fwd_in,
    input wire ch_a_rev_in,
    input wire ch_b_fwd_in,
    input wire ch_b_rev_in,
    input wire thermal_trip_in,
    input wire thermal_cool_in,
    input wire overcurrent_in,
    input wire supply_low_in,
    input wire ch_a_out_en,
    input wire ch_b_out_en,
    input wire thermal_shutdown,
    input wire overcurrent_shutdown,
    input wire undervoltage_lockout
);
    wire any_in = ch_a_fwd_in | ch_a_rev_in | ch_b_fwd_in | ch_b_rev_in;
    wire all_off = !ch_a_out_en && !ch_b_out_en;
    reg [15:0] oc_run_r;
    // The run length saturates so a stuck comparator cannot wrap it back under the blanking count.
    always @(posedge clk) begin
        if (sys_rst || !overcurrent_in)
            oc_run_r <= 16'h0;
        else if (oc_run_r != 16'hFFFF)
            oc_run_r <= oc_run_r + 16'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    therm_off_a: assert property (thermal_trip_in[*5] |-> thermal_shutdown && all_off) else $error("no trip");
    therm_hold_a: assert property ((!thermal_cool_in)[*4] ##0 $past(thermal_shutdown) |-> thermal_shutdown)
        else $error("early release");
    ocur_blank_a: assert property ($rose(overcurrent_shutdown) |-> $past(oc_run_r, 2) >= BLANK_CYC - 1)
        else $error("short trip");
    ocur_off_a: assert property (overcurrent_shutdown[*2] |-> all_off) else $error("latch on");
    ocur_latch_a: assert property (any_in[*5] ##0 overcurrent_shutdown |=> overcurrent_shutdown)
        else $error("latch lost");
    ocur_rel_a: assert property ((!any_in)[*4] ##1 (any_in && !overcurrent_in)[*5] |-> !overcurrent_shutdown)
        else $error("no release");
    uv_set_a: assert property (supply_low_in[*5] |=> undervoltage_lockout && all_off) else $error("no lockout");
    uv_rel_a: assert property ((!supply_low_in)[*5] |-> !undervoltage_lockout) else $error("lockout held");
    stby_off_a: assert property ((!any_in)[*5] |-> all_off) else $error("standby on");
    cover property ($rose(overcurrent_shutdown));
    cover property ($fell(thermal_shutdown));
    cover property ($fell(undervoltage_lockout));
endmodule
bind bfp_top bfp_props #(.BLANK_CYC(BLANK_CYC)) bfp_props_inst (.*);

// ===== testbench/tb_top.sv
// Self-checking bench for the bridge fault supervisor.
`timescale 1ns/1ps
module tb_top;
    localparam BLK = 8;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg trip = 1'b0, cool = 1'b0, oc = 1'b0, low = 1'b0, cyc = 1'b0, we = 1'b0, clr = 1'b0;
    reg [3:0] adr = 4'h0, mode = 4'h0;
    reg [31:0] wdat = 32'h0;
    wire [3:0] pins;
    wire ap, an, ae, bp, bn, be, ts, os, uv, ack;
    wire [31:0] rdat;
    integer fails = 0, cmp_count = 0, seed = 5, i;
    logic [31:0] exp_q[$];
    initial forever #2.5 clk = ~clk;
    bfp_host bfp_host_inst (.clk(clk), .mode(mode), .clear_req(clr), .pins(pins));
    bfp_top #(.BLANK_CYC(BLK)) bfp_top_inst (.clk(clk), .sys_rst(sys_rst), .ch_a_fwd_in(pins[3]),
        .ch_a_rev_in(pins[2]), .ch_b_fwd_in(pins[1]), .ch_b_rev_in(pins[0]), .thermal_trip_in(trip),
        .thermal_cool_in(cool), .overcurrent_in(oc), .supply_low_in(low), .ch_a_out_p(ap), .ch_a_out_n(an),
        .ch_a_out_en(ae), .ch_b_out_p(bp), .ch_b_out_n(bn), .ch_b_out_en(be), .thermal_shutdown(ts),
        .overcurrent_shutdown(os), .undervoltage_lockout(uv), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    task end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, fails);
            if (fails == 0 && cmp_count > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    task check(input string what, input [31:0] e, input [31:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== e) begin
                fails = fails + 1;
                $display("wrong value %s expected %h seen %h", what, e, got);
            end
        end
    endtask
    // A read notes its expected word; the monitor below compares it when ack comes.
    task wb(input w, input [3:0] a, input [31:0] d, input [31:0] e);
        integer n;
        begin
            if (!w)
                exp_q.push_back(e);
            @(posedge clk);
            cyc <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (ack !== 1'b1 && n < 20);
            if (n >= 20) begin
                fails = fails + 1;
                end_of_test;
            end
            cyc <= 1'b0;
            we <= 1'b0;
        end
    endtask
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0)
            check("read data", exp_q.size() ? exp_q.pop_front() : 32'hDEAD, rdat);
    end
    // Outputs settle three edges after a pin change; five cycles leave margin for the host register.
    task pins_chk(input [5:0] e);
        begin
            repeat (5) @(posedge clk);
            check("bridge outputs", {26'h0, e}, {ae, ap, an, be, bp, bn});
        end
    endtask
    task oc_pulse(input integer n);
        begin
            oc <= 1'b1;
            repeat (n) @(posedge clk);
            oc <= 1'b0;
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        wb(0, 4'h0, 0, 32'h8);
        wb(0, 4'hC, 0, 32'h0);
        mode <= 4'h9;
        pins_chk(6'h35);
        wb(0, 4'h0, 0, 32'h90);
        mode <= 4'hD;
        pins_chk(6'h35);
        mode <= 4'h5;
        pins_chk(6'h2D);
        $display("end of decode test");
        wb(1, 4'h4, 1, 0);
        pins_chk(6'h00);
        wb(0, 4'h4, 0, 32'h1);
        wb(1, 4'h4, 0, 0);
        pins_chk(6'h2D);
        $display("end of force test");
        trip <= 1'b1;
        pins_chk(6'h00);
        check("thermal flag", 1, ts);
        trip <= 1'b0;
        pins_chk(6'h00);
        cool <= 1'b1;
        pins_chk(6'h2D);
        cool <= 1'b0;
        low <= 1'b1;
        pins_chk(6'h00);
        check("lockout flag", 1, uv);
        low <= 1'b0;
        pins_chk(6'h2D);
        $display("end of thermal and supply test");
        oc_pulse(BLK - 2);
        pins_chk(6'h2D);
        oc_pulse(BLK + 4);
        pins_chk(6'h00);
        check("overcurrent flag", 1, os);
        for (i = 0; i < 4; i = i + 1) begin
            mode <= 4'h1 | 4'($random(seed));
            pins_chk(6'h00);
        end
        mode <= 4'h5;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (6) @(posedge clk);
        pins_chk(6'h2D);
        oc_pulse(BLK + 4);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset leaves the standby flag set, so leaving standby would also clear the latch; look before that.
        check("overcurrent flag", 0, os);
        pins_chk(6'h2D);
        $display("end of overcurrent test");
        end_of_test;
    end
endmodule
